// ---- ddrc_channel.sv ----
`timescale 1ns/1ps
`default_nettype none
// one converter channel: byte holding registers and the presented code
module ddrc_channel
  import ddrc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // register writes
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_low,
  input  wire logic        wr_high,
  // control
  input  wire logic        mode8,
  input  wire logic        sync_on,
  input  wire logic        sync_rise,
  // state
  output logic      [7:0]  code_low_byte,
  output logic      [7:0]  code_high_byte,
  output logic      [11:0] code
);
  logic [11:0] staged;
  logic        take;

  // 12-bit right-justified, 8-bit uses the low byte alone
  assign staged = mode8 ? {NIBBLE_ZERO, wdata}
                        : {code_high_byte[3:0], wdata};
  // the high byte alone never reaches the output
  assign take = wr_low & sync_on;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      code_low_byte  <= DATA_RESET;
      code_high_byte <= DATA_RESET;
    end else begin
      if (wr_low)
        code_low_byte <= wdata;
      if (wr_high)
        code_high_byte <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn)
      code <= CODE_RESET;
    else if (take)
      code <= staged;
    else if (sync_rise)
      code <= mode8 ? {NIBBLE_ZERO, code_low_byte}
                    : {code_high_byte[3:0], code_low_byte};
  end

  a_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr_high && !wr_low && !sync_rise) |=> $stable(code))
    else $error("high byte write moved the code");
  a_low_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr_low && sync_on && !mode8) |=> code == {$past(code_high_byte[3:0]), $past(wdata)})
    else $error("low byte write did not update code");
  a_mode8_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr_low && sync_on && mode8) |=> code == {NIBBLE_ZERO, $past(wdata)})
    else $error("8-bit code wrong");
endmodule : ddrc_channel
`default_nettype wire

// ---- ddrc_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// core side of the register bus: one strobe per access, driven at the falling edge
module ddrc_cpu_model (
  // clock
  input  wire logic       clk,
  // register bus
  output logic      [7:0] sfr_addr,
  output logic      [7:0] sfr_wdata,
  output logic            sfr_wr,
  output logic            sfr_rd,
  input  wire logic [7:0] sfr_rdata,
  input  wire logic       sfr_hit
);
  initial begin
    sfr_addr  = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr    = 1'b0;
    sfr_rd    = 1'b0;
  end
  // released lines show the inverse, so a stale value never passes for a live one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge clk);
    sfr_wr    = 1'b0;
    sfr_addr  = ~a;
    sfr_wdata = ~d;
  endtask : wr
  // rdata holds until the next read, so a late sample is safe
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(posedge clk);
    h = sfr_hit;
    @(negedge clk);
    sfr_rd   = 1'b0;
    sfr_addr = ~a;
    @(negedge clk);
    d = sfr_rdata;
  endtask : rd
  // high byte first, so the low write presents a whole code
  task automatic wr_code(input logic [7:0] lo_a, input logic [15:0] v);
    wr(lo_a + 8'h01, v[15:8]);
    wr(lo_a, v[7:0]);
  endtask : wr_code
endmodule : ddrc_cpu_model
`default_nettype wire

// ---- ddrc_pkg.sv ----
package ddrc_pkg;
  // special-function-register addresses
  localparam logic [7:0] ADDR_CONVERTER_CONTROL = 8'hED;
  localparam logic [7:0] ADDR_CHAN0_CODE_LOW    = 8'hF9;
  localparam logic [7:0] ADDR_CHAN0_CODE_HIGH   = 8'hFA;
  localparam logic [7:0] ADDR_CHAN1_CODE_LOW    = 8'hFB;
  localparam logic [7:0] ADDR_CHAN1_CODE_HIGH   = 8'hFC;
  // control field positions
  localparam int BIT_MODE8   = 7;
  localparam int BIT_RANGE1  = 6;
  localparam int BIT_RANGE0  = 5;
  localparam int BIT_CLEAR1  = 4;
  localparam int BIT_CLEAR0  = 3;
  localparam int BIT_SYNC    = 2;
  localparam int BIT_POWER1  = 1;
  localparam int BIT_POWER0  = 0;
  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h04;
  localparam logic [7:0] DATA_RESET    = 8'h00;
  localparam logic [11:0] CODE_RESET   = 12'h000;
  localparam logic [3:0]  NIBBLE_ZERO  = 4'h0;
endpackage : ddrc_pkg

// ---- ddrc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddrc_top
  import ddrc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // special function register bus
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_hit,
  // converter 0 analog controls
  output logic      [11:0] chan0_code,
  output logic             chan0_range_select,
  output logic             chan0_clear_n,
  output logic             chan0_power_on,
  output logic             chan0_output_enable,
  // converter 1 analog controls
  output logic      [11:0] chan1_code,
  output logic             chan1_range_select,
  output logic             chan1_clear_n,
  output logic             chan1_power_on,
  output logic             chan1_output_enable
);
  logic [7:0]  converter_control_r;
  logic [7:0]  converter_control_nxt;
  logic        sync_rise;
  logic        wr_ctrl;
  logic        wr0l;
  logic        wr0h;
  logic        wr1l;
  logic        wr1h;
  logic        mode8;
  logic        sync_on;
  logic [7:0]  chan0_code_low;
  logic [7:0]  chan0_code_high;
  logic [7:0]  chan1_code_low;
  logic [7:0]  chan1_code_high;
  logic [11:0] code0;
  logic [11:0] code1;
  logic [7:0]  rd_mux;

  // address decode
  assign wr_ctrl = sfr_wr && (sfr_addr == ADDR_CONVERTER_CONTROL);
  assign wr0l    = sfr_wr && (sfr_addr == ADDR_CHAN0_CODE_LOW);
  assign wr0h    = sfr_wr && (sfr_addr == ADDR_CHAN0_CODE_HIGH);
  assign wr1l    = sfr_wr && (sfr_addr == ADDR_CHAN1_CODE_LOW);
  assign wr1h    = sfr_wr && (sfr_addr == ADDR_CHAN1_CODE_HIGH);

  assign converter_control_nxt = wr_ctrl ? sfr_wdata : converter_control_r;
  assign mode8   = converter_control_r[BIT_MODE8];
  assign sync_on = converter_control_r[BIT_SYNC];
  // the writer orders high then low, so a pending pair is whole
  assign sync_rise = wr_ctrl && sfr_wdata[BIT_SYNC] && !sync_on;

  always_ff @(posedge clk) begin
    if (!rstn)
      converter_control_r <= CONTROL_RESET;
    else
      converter_control_r <= converter_control_nxt;
  end

  ddrc_channel u_chan0 (
    .clk            (clk),
    .rstn           (rstn),
    .wdata          (sfr_wdata),
    .wr_low         (wr0l),
    .wr_high        (wr0h),
    .mode8          (mode8),
    .sync_on        (sync_on),
    .sync_rise      (sync_rise),
    .code_low_byte  (chan0_code_low),
    .code_high_byte (chan0_code_high),
    .code           (code0)
  );

  ddrc_channel u_chan1 (
    .clk            (clk),
    .rstn           (rstn),
    .wdata          (sfr_wdata),
    .wr_low         (wr1l),
    .wr_high        (wr1h),
    .mode8          (mode8),
    .sync_on        (sync_on),
    .sync_rise      (sync_rise),
    .code_low_byte  (chan1_code_low),
    .code_high_byte (chan1_code_high),
    .code           (code1)
  );

  // readback of every register; other addresses belong to other blocks
  always_comb begin
    unique case (sfr_addr)
      ADDR_CONVERTER_CONTROL: rd_mux = converter_control_r;
      ADDR_CHAN0_CODE_LOW:    rd_mux = chan0_code_low;
      ADDR_CHAN0_CODE_HIGH:   rd_mux = chan0_code_high;
      ADDR_CHAN1_CODE_LOW:    rd_mux = chan1_code_low;
      ADDR_CHAN1_CODE_HIGH:   rd_mux = chan1_code_high;
      default:                rd_mux = DATA_RESET;
    endcase
  end

  assign sfr_hit = (sfr_addr == ADDR_CONVERTER_CONTROL) ||
                   ((sfr_addr >= ADDR_CHAN0_CODE_LOW) && (sfr_addr <= ADDR_CHAN1_CODE_HIGH));

  always_ff @(posedge clk) begin
    if (!rstn)
      sfr_rdata <= DATA_RESET;
    else if (sfr_rd)
      sfr_rdata <= rd_mux;
  end

  // cleared channels present code zero so the output sits at 0 V
  assign chan0_code = chan0_clear_n ? code0 : CODE_RESET;
  assign chan1_code = chan1_clear_n ? code1 : CODE_RESET;
  assign chan1_range_select  = converter_control_r[BIT_RANGE1];
  assign chan0_range_select  = converter_control_r[BIT_RANGE0];
  assign chan1_clear_n       = converter_control_r[BIT_CLEAR1];
  assign chan0_clear_n       = converter_control_r[BIT_CLEAR0];
  assign chan1_power_on      = converter_control_r[BIT_POWER1];
  assign chan0_power_on      = converter_control_r[BIT_POWER0];
  // powered-off buffers float
  assign chan1_output_enable = chan1_power_on;
  assign chan0_output_enable = chan0_power_on;

  sequence s_pending_write;
    sfr_wr && !sync_on && (sfr_addr == ADDR_CHAN0_CODE_LOW);
  endsequence

  sequence s_pending_write1;
    sfr_wr && !sync_on && (sfr_addr == ADDR_CHAN1_CODE_LOW);
  endsequence

  sequence s_sync_set;
    sync_rise;
  endsequence

  sequence s_high_write0;
    wr0h;
  endsequence

  sequence s_high_write1;
    wr1h;
  endsequence

  sequence s_imm_low0;
    wr0l && sync_on;
  endsequence

  sequence s_imm_low1;
    wr1l && sync_on;
  endsequence

  sequence s_ctrl_write;
    wr_ctrl;
  endsequence

  // reset checks run without disable so the reset itself is covered
  ctrl_reset_a: assert property (@(posedge clk)
    !rstn |=> converter_control_r == CONTROL_RESET)
    else $error("control reset value wrong");

  off_float_a: assert property (@(posedge clk)
    !rstn |=> !chan0_output_enable && !chan1_output_enable)
    else $error("outputs not floating after reset");

  data_reset_a: assert property (@(posedge clk)
    !rstn |=> chan0_code_low == DATA_RESET && chan0_code_high == DATA_RESET &&
              chan1_code_low == DATA_RESET && chan1_code_high == DATA_RESET)
    else $error("data reset value wrong");

  code_reset_a: assert property (@(posedge clk)
    !rstn |=> code0 == CODE_RESET && code1 == CODE_RESET)
    else $error("code reset value wrong");

  rdata_reset_a: assert property (@(posedge clk)
    !rstn |=> sfr_rdata == DATA_RESET)
    else $error("read data reset value wrong");

  sync_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    s_pending_write |=> $stable(code0))
    else $error("held write reached output");

  sync_hold1_a: assert property (@(posedge clk) disable iff (!rstn)
    s_pending_write1 |=> $stable(code1))
    else $error("held write reached output 1");

  sync_both_a: assert property (@(posedge clk) disable iff (!rstn)
    s_sync_set |=> code0[7:0] == chan0_code_low && code1[7:0] == chan1_code_low)
    else $error("sync set did not update both");

  sync_full0_a: assert property (@(posedge clk) disable iff (!rstn)
    s_sync_set |=> code0[11:8] == ($past(mode8) ? NIBBLE_ZERO : $past(chan0_code_high[3:0])))
    else $error("sync set upper bits wrong on 0");

  sync_full1_a: assert property (@(posedge clk) disable iff (!rstn)
    s_sync_set |=> code1[11:8] == ($past(mode8) ? NIBBLE_ZERO : $past(chan1_code_high[3:0])))
    else $error("sync set upper bits wrong on 1");

  imm_update_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr1l && sync_on) |=> code1[7:0] == $past(sfr_wdata))
    else $error("immediate update missed");

  imm_low0_a: assert property (@(posedge clk) disable iff (!rstn)
    s_imm_low0 |=> code0[7:0] == $past(sfr_wdata))
    else $error("immediate update missed on 0");

  imm_full0_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr0l && sync_on && !mode8) |=> code0[11:8] == $past(chan0_code_high[3:0]))
    else $error("upper nibble not taken on 0");

  imm_full1_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr1l && sync_on && !mode8) |=> code1[11:8] == $past(chan1_code_high[3:0]))
    else $error("upper nibble not taken on 1");

  imm8_zero0_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr0l && sync_on && mode8) |=> code0[11:8] == NIBBLE_ZERO)
    else $error("8-bit upper bits not zero on 0");

  imm8_zero1_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr1l && sync_on && mode8) |=> code1[11:8] == NIBBLE_ZERO)
    else $error("8-bit upper bits not zero on 1");

  hold_high0_a: assert property (@(posedge clk) disable iff (!rstn)
    s_high_write0 |=> $stable(code0))
    else $error("high byte write moved code 0");

  hold_high1_a: assert property (@(posedge clk) disable iff (!rstn)
    s_high_write1 |=> $stable(code1))
    else $error("high byte write moved code 1");

  no_write_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    !sfr_wr |=> $stable(code0) && $stable(code1))
    else $error("code moved without a write");

  clear_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    !converter_control_r[BIT_CLEAR0] |-> chan0_code == CODE_RESET)
    else $error("clear did not force zero");

  clear_zero1_a: assert property (@(posedge clk) disable iff (!rstn)
    !converter_control_r[BIT_CLEAR1] |-> chan1_code == CODE_RESET)
    else $error("clear did not force zero on 1");

  clear_pass_a: assert property (@(posedge clk) disable iff (!rstn)
    (chan0_clear_n && chan1_clear_n) |-> chan0_code == code0 && chan1_code == code1)
    else $error("uncleared code not presented");

  mode_bit_a: assert property (@(posedge clk) disable iff (!rstn)
    s_ctrl_write |=> mode8 == $past(sfr_wdata[BIT_MODE8]) &&
                     chan1_range_select == $past(sfr_wdata[BIT_RANGE1]))
    else $error("mode or range not taken");

  power_bit_a: assert property (@(posedge clk) disable iff (!rstn)
    s_ctrl_write |=> chan0_power_on == $past(sfr_wdata[BIT_POWER0]) &&
                     chan0_range_select == $past(sfr_wdata[BIT_RANGE0]))
    else $error("power or range not taken");

  power1_take_a: assert property (@(posedge clk) disable iff (!rstn)
    s_ctrl_write |=> chan1_power_on == $past(sfr_wdata[BIT_POWER1]) &&
                     chan1_clear_n == $past(sfr_wdata[BIT_CLEAR1]))
    else $error("power or clear of 1 not taken");

  clear0_take_a: assert property (@(posedge clk) disable iff (!rstn)
    s_ctrl_write |=> chan0_clear_n == $past(sfr_wdata[BIT_CLEAR0]) &&
                     sync_on == $past(sfr_wdata[BIT_SYNC]))
    else $error("clear or sync not taken");

  ctrl_take_a: assert property (@(posedge clk) disable iff (!rstn)
    s_ctrl_write |=> converter_control_r == $past(sfr_wdata))
    else $error("control write not taken");

  ctrl_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    !wr_ctrl |=> $stable(converter_control_r))
    else $error("control moved without a write");

  read_ctrl_a: assert property (@(posedge clk) disable iff (!rstn)
    (sfr_rd && sfr_addr == ADDR_CONVERTER_CONTROL) |=> sfr_rdata == $past(converter_control_r))
    else $error("control readback wrong");

  read_low0_a: assert property (@(posedge clk) disable iff (!rstn)
    (sfr_rd && sfr_addr == ADDR_CHAN0_CODE_LOW) |=> sfr_rdata == $past(chan0_code_low))
    else $error("low byte 0 readback wrong");

  read_high0_a: assert property (@(posedge clk) disable iff (!rstn)
    (sfr_rd && sfr_addr == ADDR_CHAN0_CODE_HIGH) |=> sfr_rdata == $past(chan0_code_high))
    else $error("high byte 0 readback wrong");

  read_low1_a: assert property (@(posedge clk) disable iff (!rstn)
    (sfr_rd && sfr_addr == ADDR_CHAN1_CODE_LOW) |=> sfr_rdata == $past(chan1_code_low))
    else $error("low byte 1 readback wrong");

  read_high1_a: assert property (@(posedge clk) disable iff (!rstn)
    (sfr_rd && sfr_addr == ADDR_CHAN1_CODE_HIGH) |=> sfr_rdata == $past(chan1_code_high))
    else $error("high byte 1 readback wrong");

  read_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    !sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");

  store_low_a: assert property (@(posedge clk) disable iff (!rstn)
    wr0l |=> chan0_code_low == $past(sfr_wdata))
    else $error("low byte 0 not stored");

  store_high_a: assert property (@(posedge clk) disable iff (!rstn)
    wr1h |=> chan1_code_high == $past(sfr_wdata))
    else $error("high byte 1 not stored");
endmodule : ddrc_top
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_top;
  import ddrc_pkg::*;
  logic        clk;
  logic        rstn;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, rv;
  logic        sfr_wr, sfr_rd, sfr_hit, hv;
  logic [11:0] chan0_code, chan1_code;
  logic        chan0_range_select, chan0_clear_n, chan0_power_on, chan0_output_enable;
  logic        chan1_range_select, chan1_clear_n, chan1_power_on, chan1_output_enable;
  int          err_count = 0;
  int          cmp_count = 0;
  logic [7:0]  addr_tab [6] = '{8'hED, 8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'h80};
  logic [7:0]  rst_tab  [6] = '{8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  ddrc_top i_ddrc_top (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .chan0_code(chan0_code), .chan0_range_select(chan0_range_select),
    .chan0_clear_n(chan0_clear_n), .chan0_power_on(chan0_power_on),
    .chan0_output_enable(chan0_output_enable), .chan1_code(chan1_code),
    .chan1_range_select(chan1_range_select), .chan1_clear_n(chan1_clear_n),
    .chan1_power_on(chan1_power_on), .chan1_output_enable(chan1_output_enable));
  ddrc_cpu_model u_cpu (.clk(clk), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit));
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // whole sequence is under a hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
  initial begin
    rstn = 1'b0;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    `CHK({chan1_output_enable, chan0_output_enable, chan1_power_on, chan0_power_on}, 4'h0)
    `CHK({chan1_clear_n, chan0_clear_n, chan1_range_select, chan0_range_select}, 4'h0)
    for (int i = 0; i < 6; i++) begin
      u_cpu.rd(addr_tab[i], rv, hv);
      `CHK(rv, rst_tab[i])
      `CHK(hv, i < 5)
    end
    u_cpu.wr(ADDR_CONVERTER_CONTROL, 8'h1F);
    `CHK({chan1_output_enable, chan0_output_enable, chan1_power_on, chan0_power_on}, 4'hF)
    u_cpu.wr(ADDR_CHAN0_CODE_HIGH, 8'h35);
    `CHK(chan0_code, 12'h000)
    u_cpu.wr(ADDR_CHAN0_CODE_LOW, 8'h34);
    `CHK(chan0_code, 12'h534)
    u_cpu.rd(ADDR_CHAN0_CODE_HIGH, rv, hv);
    `CHK(rv, 8'h35)
    `CHK(hv, 1'b1)
    u_cpu.wr(ADDR_CONVERTER_CONTROL, 8'h5F);
    `CHK({chan1_range_select, chan0_range_select}, 2'h2)
    u_cpu.wr(ADDR_CONVERTER_CONTROL, 8'h3F);
    `CHK({chan1_range_select, chan0_range_select}, 2'h1)
    // sync clear: both channels loaded, nothing may move until the bit rises
    u_cpu.wr(ADDR_CONVERTER_CONTROL, 8'h1B);
    u_cpu.wr_code(ADDR_CHAN0_CODE_LOW, 16'h0123);
    u_cpu.wr_code(ADDR_CHAN1_CODE_LOW, 16'hFABC);
    `CHK({chan1_code, chan0_code}, {12'h000, 12'h534})
    u_cpu.wr(ADDR_CONVERTER_CONTROL, 8'h1F);
    `CHK({chan1_code, chan0_code}, {12'hABC, 12'h123})
    u_cpu.wr(ADDR_CONVERTER_CONTROL, 8'h17);
    `CHK({chan1_code, chan0_code, chan0_clear_n}, {12'hABC, 12'h000, 1'b0})
    u_cpu.wr(ADDR_CONVERTER_CONTROL, 8'h0F);
    `CHK({chan1_code, chan0_code, chan1_clear_n}, {12'h000, 12'h123, 1'b0})
    u_cpu.wr(ADDR_CONVERTER_CONTROL, 8'h9E);
    `CHK({chan1_power_on, chan0_power_on, chan0_output_enable}, 3'h4)
    u_cpu.wr(ADDR_CHAN0_CODE_LOW, 8'hC5);
    `CHK(chan0_code, 12'h0C5)
    u_cpu.wr(ADDR_CONVERTER_CONTROL, 8'h9A);
    u_cpu.wr(ADDR_CHAN1_CODE_LOW, 8'h77);
    `CHK(chan1_code, 12'hABC)
    u_cpu.wr(ADDR_CONVERTER_CONTROL, 8'h9E);
    `CHK({chan1_code, chan0_code}, {12'h077, 12'h0C5})
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
